// >>> core/rtc_irq_device.sv
// Interrupt section of a real-time clock: alarm matching, time update
// events, event flags and the shared open-drain interrupt request.
// Assumes timekeeping counters on the same clock supply one-cycle ticks
// and BCD time values that are already updated in the tick cycle.
//
// Our own choice: the APB slave port.
`default_nettype none

module rtc_irq_device #(
	parameter int UPD_RELEASE_CYCLES = rtc_irq_pkg::UPD_RELEASE_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	rtc_irq_if.device       link,
	input  wire logic       sec_tick,
	input  wire logic       min_tick,
	input  wire logic       timer_event,
	input  wire logic       low_voltage_event,
	input  wire logic [2:0] weekday,
	input  wire logic [5:0] date_bcd,
	input  wire logic [5:0] hour_bcd,
	input  wire logic [6:0] minute_bcd,
	output logic            stop_clock,
	output logic            timer_run,
	output logic            timer_pause,
	output logic [2:0]      timer_source_select,
	output logic [1:0]      clock_out_select
);
	import rtc_irq_pkg::*;

	localparam int CNT_W = $clog2(UPD_RELEASE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UPD_RELEASE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	logic [7:0]       alm_min_r;
	logic [7:0]       alm_hour_r;
	logic [7:0]       alm_day_r;
	logic [7:0]       function_select_ext_r;
	logic [7:0]       event_flag_bank_r;
	logic [7:0]       event_flag_bank_nxt;
	logic [7:0]       irq_enable_control_r;
	logic             ack_r;
	logic [7:0]       rdata_r;
	logic             upd_active_r;
	logic [CNT_W-1:0] upd_cnt_r;
	logic             irq_oe_n_r;
	logic             take;
	logic             wr_take;
	logic             stop;
	logic             upd_evt;
	logic             alm_evt;
	logic             min_ok;
	logic             hour_ok;
	logic             day_ok;
	logic             upd_clear;
	logic             pull_low;

	////////////////////////////////////////////////////////////////////
	// Register port decode: one request per ack, ack spaced by a cycle
	assign take    = ce && link.reg_req && !ack_r;
	assign wr_take = take && link.reg_we;
	assign stop    = irq_enable_control_r[CTRL_STOP_BIT];

	// Acknowledge and read data, both registered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_r   <= 1'b0;
			rdata_r <= REG_RESET;
		end else if (ce) begin
			ack_r <= take;
			if (take && !link.reg_we) begin
				case (link.reg_addr)
					REG_ALM_MIN:  rdata_r <= alm_min_r;
					REG_ALM_HOUR: rdata_r <= alm_hour_r;
					REG_ALM_DAY:  rdata_r <= alm_day_r;
					REG_EXT:      rdata_r <= function_select_ext_r;
					REG_FLAG:     rdata_r <= event_flag_bank_r;
					REG_CTRL:     rdata_r <= irq_enable_control_r;
					default:      rdata_r <= REG_RESET;
				endcase
			end
		end
	end

	// Plain read/write registers; unused control bits read zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alm_min_r             <= REG_RESET;
			alm_hour_r            <= REG_RESET;
			alm_day_r             <= REG_RESET;
			function_select_ext_r <= REG_RESET;
			irq_enable_control_r  <= REG_RESET;
		end else if (wr_take) begin
			case (link.reg_addr)
				REG_ALM_MIN:  alm_min_r <= link.reg_wdata;
				REG_ALM_HOUR: alm_hour_r <= link.reg_wdata;
				REG_ALM_DAY:  alm_day_r <= link.reg_wdata;
				REG_EXT:      function_select_ext_r <= link.reg_wdata;
				REG_CTRL:     irq_enable_control_r <=
					link.reg_wdata & CTRL_RW_MASK;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alarm comparison, evaluated on the minute carry only, so a setting
	// equal to the present time fires at its next occurrence, not now
	assign min_ok  = alm_min_r[ALM_MASK_BIT] ||
		(alm_min_r[6:0] == minute_bcd);
	assign hour_ok = alm_hour_r[ALM_MASK_BIT] ||
		(alm_hour_r[5:0] == hour_bcd);

	// Day field: weekday bitmap or BCD date, by the select bit
	always_comb begin
		if (alm_day_r[ALM_MASK_BIT]) begin
			day_ok = 1'b1;
		end else if (function_select_ext_r[EXT_DAY_SEL_BIT]) begin
			day_ok = (alm_day_r[5:0] == date_bcd);
		end else begin
			day_ok = (weekday < DAYS_PER_WEEK) &&
				alm_day_r[weekday];
		end
	end

	assign alm_evt = ce && !stop && min_tick &&
		min_ok && hour_ok && day_ok;

	// Update event source; stop freezes the clock so no update or alarm events either
	assign upd_evt = ce && !stop && (function_select_ext_r[EXT_UPD_SEL_BIT] ?
		min_tick : sec_tick);

	////////////////////////////////////////////////////////////////////
	// Event flags: writing 0 clears, writing 1 is ignored, except in bits 7,
	// 6 and 2, which hold what is written; an event in the clearing cycle
	// wins so it is never lost
	always_comb begin
		event_flag_bank_nxt = event_flag_bank_r;
		if (wr_take && link.reg_addr == REG_FLAG) begin
			event_flag_bank_nxt = event_flag_bank_r &
				(link.reg_wdata | ~FLAG_CLR_MASK);
			event_flag_bank_nxt = (event_flag_bank_nxt & ~FLAG_RW_MASK) |
				(link.reg_wdata & FLAG_RW_MASK);
		end
		if (upd_evt) begin
			event_flag_bank_nxt[FLAG_UPD_BIT] = 1'b1;
		end
		if (alm_evt) begin
			event_flag_bank_nxt[FLAG_ALM_BIT] = 1'b1;
		end
		if (ce && timer_event) begin
			event_flag_bank_nxt[FLAG_TMR_BIT] = 1'b1;
		end
		if (ce && low_voltage_event) begin
			event_flag_bank_nxt[FLAG_LOWV_BIT] = 1'b1;
		end
	end

	// Flags rise whatever the enables hold, so polling always works
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			event_flag_bank_r <= REG_RESET;
		end else begin
			event_flag_bank_r <= event_flag_bank_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Update pulse window: the pin share of an update ends by itself
	assign upd_clear = wr_take && link.reg_addr == REG_FLAG &&
		!link.reg_wdata[FLAG_UPD_BIT];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upd_active_r <= 1'b0;
			upd_cnt_r    <= CNT_ZERO;
		end else if (ce) begin
			if (upd_evt) begin
				upd_active_r <= 1'b1;
				upd_cnt_r    <= CNT_ZERO;
			end else if (upd_clear) begin
				upd_active_r <= 1'b0;
			end else if (upd_active_r) begin
				if (upd_cnt_r == CNT_LAST) begin
					upd_active_r <= 1'b0;
				end else begin
					upd_cnt_r <= upd_cnt_r + 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared request: alarm or timer with flag and enable both set, or update with flag and enable set inside its window, pulls low; low voltage never does.
	// Registered, so the pin follows an event two edges later, far inside
	// the allowed delay after an update.
	assign pull_low =
		(event_flag_bank_r[FLAG_ALM_BIT] &&
		 irq_enable_control_r[CTRL_ALM_EN_BIT]) ||
		(event_flag_bank_r[FLAG_TMR_BIT] &&
		 irq_enable_control_r[CTRL_TMR_EN_BIT]) ||
		(event_flag_bank_r[FLAG_UPD_BIT] && upd_active_r &&
		 irq_enable_control_r[CTRL_UPD_EN_BIT]);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_oe_n_r <= 1'b1;
		end else if (ce) begin
			irq_oe_n_r <= !pull_low;
		end
	end

	// Open drain: data is always low, only the enable moves
	assign link.irq_out   = 1'b0;
	assign link.irq_oe_n  = irq_oe_n_r;
	assign link.reg_ack   = ack_r;
	assign link.reg_rdata = rdata_r;

	// Control fields for the neighbouring timekeeping blocks
	assign stop_clock          = irq_enable_control_r[CTRL_STOP_BIT];
	assign timer_pause         = irq_enable_control_r[CTRL_PAUSE_BIT];
	assign timer_run           = function_select_ext_r[EXT_RUN_BIT];
	assign timer_source_select = function_select_ext_r[EXT_TSEL_LSB +: 3];
	assign clock_out_select    = function_select_ext_r[EXT_FSEL_LSB +: 2];
endmodule : rtc_irq_device
`default_nettype wire

// >>> core/rtc_irq_host.sv
// Host end: an APB slave that turns software commands into single
// register accesses on the clock chip and reports the request line.
// Assumes the device acknowledges every request on the same clock.
`default_nettype none
module rtc_irq_host (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	rtc_irq_if.host          link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq_pending
);
	import rtc_irq_pkg::*;

	typedef enum logic {ST_IDLE, ST_WAIT} link_state_e;

	link_state_e state_r;
	logic        req_r;
	logic        we_r;
	logic [7:0]  addr_r;
	logic [7:0]  wdata_r;
	logic [7:0]  rdata_r;
	logic        irq_meta_r;
	logic        irq_sync_r;
	logic        irq_pending_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic        setup;
	logic        mapped;
	logic        cmd_take;

	////////////////////////////////////////////////////////////////////
	// APB: answer registered in the setup cycle, so one access cycle
	assign setup    = psel && !penable;
	assign mapped   = (paddr == APB_CMD_OFS) || (paddr == APB_STAT_OFS);
	assign cmd_take = ce && psel && penable && pready_r && pwrite &&
		paddr == APB_CMD_OFS && state_r == ST_IDLE;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (ce) begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
			prdata_r  <= 32'h0000_0000;
			if (setup && !pwrite && paddr == APB_STAT_OFS) begin
				prdata_r[STAT_BUSY_BIT]       <= (state_r != ST_IDLE);
				prdata_r[STAT_IRQ_BIT]        <= irq_pending_r;
				prdata_r[STAT_RDATA_LSB +: 8] <= rdata_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link sequencer; a command while busy is dropped, so software
	// must poll busy before issuing the next one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			req_r   <= 1'b0;
			we_r    <= 1'b0;
			addr_r  <= 8'h00;
			wdata_r <= 8'h00;
			rdata_r <= 8'h00;
		end else if (ce) begin
			case (state_r)
				ST_IDLE: begin
					if (cmd_take) begin
						req_r   <= 1'b1;
						we_r    <= pwrite && pwdata[CMD_WRITE_BIT];
						addr_r  <= pwdata[CMD_ADDR_LSB +: 8];
						wdata_r <= pwdata[CMD_WDATA_LSB +: 8];
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (link.reg_ack) begin
						req_r   <= 1'b0;
						rdata_r <= link.reg_rdata;
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Request line is a pin: two flops before use, then a status flop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_meta_r    <= 1'b1;
			irq_sync_r    <= 1'b1;
			irq_pending_r <= 1'b0;
		end else if (ce) begin
			irq_meta_r    <= link.irq_line;
			irq_sync_r    <= irq_meta_r;
			irq_pending_r <= !irq_sync_r;
		end
	end

	assign link.reg_req   = req_r;
	assign link.reg_we    = we_r;
	assign link.reg_addr  = addr_r;
	assign link.reg_wdata = wdata_r;
	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign irq_pending    = irq_pending_r;
endmodule : rtc_irq_host
`default_nettype wire

// >>> core/rtc_irq_if.sv
// Link between host and clock chip: register port plus the shared
// open-drain interrupt request line, resolved here with a pull-up.
`default_nettype none
interface rtc_irq_if;
	logic       reg_req;
	logic       reg_we;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_ack;
	logic [7:0] reg_rdata;
	logic       irq_out;
	logic       irq_oe_n;
	logic       irq_line;

	// Pull-up wins unless the device enables its low driver
	assign irq_line = irq_oe_n ? 1'b1 : irq_out;

	modport device (
		input  reg_req, reg_we, reg_addr, reg_wdata,
		output reg_ack, reg_rdata, irq_out, irq_oe_n
	);
	modport host (
		output reg_req, reg_we, reg_addr, reg_wdata,
		input  reg_ack, reg_rdata, irq_line
	);
endinterface : rtc_irq_if
`default_nettype wire

// >>> core/rtc_irq_pkg.sv
// Shared constants of the clock-chip interrupt logic and its host end.
// Assumes a 40 MHz system clock and 8-bit device registers.
`default_nettype none
package rtc_irq_pkg;
	// Device register map
	localparam logic [7:0] REG_ALM_MIN   = 8'h08;
	localparam logic [7:0] REG_ALM_HOUR  = 8'h09;
	localparam logic [7:0] REG_ALM_DAY   = 8'h0a;
	localparam logic [7:0] REG_EXT       = 8'h0d;
	localparam logic [7:0] REG_FLAG      = 8'h0e;
	localparam logic [7:0] REG_CTRL      = 8'h0f;
	// Field positions
	localparam int ALM_MASK_BIT  = 7;
	localparam int EXT_UPD_SEL_BIT = 5;
	localparam int EXT_DAY_SEL_BIT = 3;
	localparam int EXT_RUN_BIT     = 4;
	localparam int EXT_TSEL_LSB    = 0;
	localparam int EXT_FSEL_LSB    = 6;
	localparam int FLAG_UPD_BIT    = 5;
	localparam int FLAG_TMR_BIT    = 4;
	localparam int FLAG_ALM_BIT    = 3;
	localparam int FLAG_LOWV_BIT   = 1;
	localparam int CTRL_UPD_EN_BIT = 5;
	localparam int CTRL_TMR_EN_BIT = 4;
	localparam int CTRL_ALM_EN_BIT = 3;
	localparam int CTRL_PAUSE_BIT  = 2;
	localparam int CTRL_STOP_BIT   = 1;
	// Access masks and reset values
	localparam logic [7:0] CTRL_RW_MASK  = 8'h3e;
	localparam logic [7:0] FLAG_RW_MASK  = 8'hc4;
	localparam logic [7:0] FLAG_CLR_MASK = 8'h3a;
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [2:0] DAYS_PER_WEEK = 3'h7;
	// Timing
	localparam int CLK_HZ          = 40_000_000;
	localparam int UPD_RELEASE_US  = 7813;
	localparam int UPD_RELEASE_CYC = UPD_RELEASE_US * (CLK_HZ / 1_000_000);
	// Host APB register map
	localparam logic [31:0] APB_CMD_OFS  = 32'h0000_0000;
	localparam logic [31:0] APB_STAT_OFS = 32'h0000_0004;
	localparam int CMD_WDATA_LSB  = 0;
	localparam int CMD_ADDR_LSB   = 8;
	localparam int CMD_WRITE_BIT  = 16;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_IRQ_BIT   = 1;
	localparam int STAT_RDATA_LSB = 8;
endpackage : rtc_irq_pkg
`default_nettype wire

// >>> tb/rtc_irq_props.sv
// Checker on the link between host end and clock-chip end.
// Assumes ce stays high and a pull-up on the request line.
`default_nettype none
module rtc_irq_props
	import rtc_irq_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       reg_req,
	input  wire logic       reg_we,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_ack,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       irq_out,
	input  wire logic       irq_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////
	// Request taken at this edge; a held request is not taken twice
	logic tk;
	assign tk = reg_req && !reg_ack;

	property p_ack;
		tk |=> reg_ack ##1 !reg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_idle;
		!reg_req |=> !reg_ack;
	endproperty
	a_idle: assert property (p_idle) else $error("ack unasked");
	property p_hold;
		tk |=> reg_req && $stable(reg_addr) && $stable(reg_we);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_ctrl;
		tk && !reg_we && reg_addr == REG_CTRL
			|=> (reg_rdata & ~CTRL_RW_MASK) == 8'h00;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("ctrl spare bits");
	property p_flag0;
		tk && !reg_we && reg_addr == REG_FLAG |=> !reg_rdata[0];
	endproperty
	a_flag0: assert property (p_flag0) else $error("flag bit0");
	property p_unmap;
		tk && !reg_we && reg_addr >= 8'h10 |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	// Read data only moves when a read is taken
	property p_keep;
		!(tk && !reg_we) |=> $stable(reg_rdata);
	endproperty
	a_keep: assert property (p_keep) else $error("rdata moved");
	// All enables off after the last taken control write; reset clears them
	logic quiet_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			quiet_r <= 1'b1;
		end else if (tk && reg_we && reg_addr == REG_CTRL) begin
			quiet_r <= {reg_wdata[CTRL_UPD_EN_BIT], reg_wdata[CTRL_TMR_EN_BIT],
				reg_wdata[CTRL_ALM_EN_BIT]} == 3'h0;
		end
	end
	// Data never high; a pin released one edge after the enables went off
	property p_od;
		irq_out == 1'b0 && (irq_oe_n || !(quiet_r && $past(quiet_r)));
	endproperty
	a_od: assert property (p_od) else $error("bad pin");
	property p_off;
		tk && reg_we && reg_addr == REG_CTRL && reg_wdata[5:3] == 3'h0
			|=> ##1 irq_oe_n;
	endproperty
	a_off: assert property (p_off) else $error("pin low, enables 0");
endmodule : rtc_irq_props
`default_nettype wire

// >>> tb/tb.sv
// Bench: host end and clock-chip end joined by their link, via APB.
// Assumes a shortened update release window; APB waits on pready.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rtc_irq_pkg::*;
	localparam int N = 60;
	logic        clk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
	logic        irqp, sec, mint, tev, lve, stp, trun, tpau, err;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [7:0]  b;
	logic [6:0]  mins;
	logic [5:0]  date, hour;
	logic [2:0]  wd, tsel;
	logic [1:0]  fsel;
	int          error_cnt, checks;
	rtc_irq_if link ();
	rtc_irq_device #(.UPD_RELEASE_CYCLES(N)) rtc_irq_device_i (
		.clk(clk), .reset_n(reset_n), .ce(ce), .link(link.device),
		.sec_tick(sec), .min_tick(mint), .timer_event(tev),
		.low_voltage_event(lve), .weekday(wd), .date_bcd(date),
		.hour_bcd(hour), .minute_bcd(mins), .stop_clock(stp),
		.timer_run(trun), .timer_pause(tpau), .timer_source_select(tsel),
		.clock_out_select(fsel)
	);
	rtc_irq_host rtc_irq_host_i (
		.clk(clk), .reset_n(reset_n), .ce(ce), .link(link.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_pending(irqp)
	);
	rtc_irq_props rtc_irq_props_i (
		.clk(clk), .reset_n(reset_n), .reg_req(link.reg_req),
		.reg_we(link.reg_we), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
		.reg_rdata(link.reg_rdata), .irq_out(link.irq_out),
		.irq_oe_n(link.irq_oe_n)
	);
	////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input logic [7:0] g, e, input string m);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : chk
	task automatic summarize();
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic fail();
		error_cnt++;
		summarize();
	endtask : fail
	// One APB transfer; answer taken at the edge that sees pready
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fail();
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Chip register access through the command word, then poll busy
	task automatic dev(input logic w, input logic [7:0] a, d);
		int n;
		apb(1'b1, APB_CMD_OFS, {15'h0, w, a, d});
		n = 0;
		do begin
			apb(1'b0, APB_STAT_OFS, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 20);
		if (n >= 20)
			fail();
		b = q[STAT_RDATA_LSB +: 8];
	endtask : dev
	task automatic rd(input logic [7:0] a, e, input string m);
		dev(1'b0, a, 8'h00);
		chk(b, e, m);
	endtask : rd
	// One-cycle event pulses: {low voltage, timer, minute, second}
	task automatic ev(input logic [3:0] k);
		@(posedge clk);
		{lve, tev, mint, sec} <= k;
		@(posedge clk);
		{lve, tev, mint, sec} <= 4'h0;
	endtask : ev
	// The pin is registered after the flag, so look one edge later
	task automatic pin(input logic e, input string m);
		@(posedge clk);
		@(negedge clk);
		chk({7'h0, link.irq_line}, {7'h0, e}, m);
	endtask : pin
	task automatic alm(input logic e, input string m);
		dev(1'b1, REG_FLAG, 8'h00);
		ev(4'h2);
		pin(~e, m);
		rd(REG_FLAG, {4'h0, e, 3'h0}, m);
	endtask : alm
	////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(REG_CTRL, 8'h00, "ctrl rst");
		rd(REG_FLAG, 8'h00, "flag rst");
		dev(1'b1, REG_CTRL, 8'hff);
		rd(REG_CTRL, CTRL_RW_MASK, "ctrl rw");
		chk({6'h0, tpau, stp}, 8'h03, "ctrl outs");
		dev(1'b1, REG_EXT, 8'hd7);
		rd(REG_EXT, 8'hd7, "ext rw");
		chk({fsel, 1'b0, trun, 1'b0, tsel}, 8'hd7, "ext outs");
		dev(1'b1, REG_FLAG, 8'hff);
		rd(REG_FLAG, FLAG_RW_MASK, "flag w1");
		rd(8'h20, 8'h00, "unmapped");
		apb(1'b0, 32'h8, 32'h0);
		chk({7'h0, err}, 8'h01, "apb slverr");
		dev(1'b1, REG_FLAG, 8'h00);
		dev(1'b1, REG_CTRL, 8'h00);
		dev(1'b1, REG_EXT, 8'h00);
	endtask : t_regs
	task automatic t_upd();
		dev(1'b1, REG_CTRL, 8'h20);
		ev(4'h1);
		pin(1'b0, "upd low");
		repeat (N - 2) @(negedge clk);
		pin(1'b0, "upd hold");
		pin(1'b1, "upd free");
		rd(REG_FLAG, 8'h20, "upd flag set");
		dev(1'b1, REG_FLAG, 8'h20);
		rd(REG_FLAG, 8'h20, "upd flag w1");
		dev(1'b1, REG_FLAG, 8'h00);
		ev(4'h1);
		pin(1'b0, "upd again");
		dev(1'b1, REG_FLAG, 8'h00);
		pin(1'b1, "upd flag clr");
		ev(4'h1);
		pin(1'b0, "upd third");
		dev(1'b1, REG_CTRL, 8'h00);
		pin(1'b1, "upd enable off");
		rd(REG_FLAG, 8'h20, "upd flag kept");
		dev(1'b1, REG_FLAG, 8'h00);
	endtask : t_upd
	// Update enable is already low before the period is changed
	task automatic t_sel();
		dev(1'b1, REG_EXT, 8'h20);
		dev(1'b1, REG_CTRL, 8'h20);
		ev(4'h1);
		pin(1'b1, "period sec");
		ev(4'h2);
		pin(1'b0, "period min");
		dev(1'b1, REG_CTRL, 8'h22);
		dev(1'b1, REG_FLAG, 8'h00);
		ev(4'h2);
		pin(1'b1, "stop pin");
		rd(REG_FLAG, 8'h00, "stop flag");
		dev(1'b1, REG_CTRL, 8'h00);
		dev(1'b1, REG_EXT, 8'h00);
	endtask : t_sel
	task automatic t_alm();
		logic [7:0] x;
		dev(1'b1, REG_ALM_MIN, 8'h59);
		dev(1'b1, REG_ALM_HOUR, 8'h18);
		dev(1'b1, REG_ALM_DAY, 8'h3e);
		dev(1'b1, REG_CTRL, 8'h08);
		hour <= 6'h18;
		mins <= 7'h59;
		for (int i = 0; i < 7; i++) begin
			x = 8'h3e >> i;
			wd <= 3'(i);
			alm(x[0], "weekday");
		end
		mins <= 7'h58;
		wd <= 3'h1;
		alm(1'b0, "min miss");
		dev(1'b1, REG_EXT, 8'h08);
		dev(1'b1, REG_ALM_DAY, 8'h15);
		dev(1'b1, REG_ALM_HOUR, 8'h07);
		dev(1'b1, REG_ALM_MIN, 8'h80);
		hour <= 6'h07;
		date <= 6'h15;
		alm(1'b1, "date hit");
		wd <= 3'h0;
		date <= 6'h14;
		alm(1'b0, "date miss");
		dev(1'b1, REG_ALM_DAY, 8'h80);
		dev(1'b1, REG_ALM_HOUR, 8'h80);
		alm(1'b1, "all masked");
		dev(1'b1, REG_CTRL, 8'h00);
		pin(1'b1, "alm enable off");
		rd(REG_FLAG, 8'h08, "alm flag kept");
		dev(1'b1, REG_CTRL, 8'h08);
		pin(1'b0, "alm enable on");
		dev(1'b1, REG_FLAG, 8'h00);
		pin(1'b1, "alm flag clr");
		dev(1'b1, REG_CTRL, 8'h00);
	endtask : t_alm
	task automatic t_tmr();
		dev(1'b1, REG_CTRL, 8'h10);
		ev(4'h4);
		pin(1'b0, "timer pin");
		repeat (4) @(negedge clk);
		chk({7'h0, irqp}, 8'h01, "pending");
		apb(1'b0, APB_STAT_OFS, 32'h0);
		chk({7'h0, q[STAT_IRQ_BIT]}, 8'h01, "stat irq");
		rd(REG_FLAG, 8'h10, "tmr flag set");
		dev(1'b1, REG_CTRL, 8'h00);
		pin(1'b1, "tmr enable off");
		ev(4'hf);
		pin(1'b1, "all off");
		rd(REG_FLAG, 8'h3a, "all flags");
	endtask : t_tmr
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Reset, then scenarios in turn
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{sec, mint, tev, lve, wd, date, hour, mins} = '0;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_upd();
		t_sel();
		t_alm();
		t_tmr();
		summarize();
	end
endmodule : tb
`default_nettype wire
